/* tpfr_pkg.sv */
// Purpose: constants and carrier types of the timer extension block
// Assumes: one clock (apb clock, 125 MHz), byte offsets on a 12-bit apb address
// Notes:   offsets, field positions and reset values are named once here

package tpfr_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_LOAD   = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_VALUE  = 12'h404;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h408;
  localparam logic [ADDR_W-1:0] OFF_MASKED = 12'h40C;
  localparam logic [ADDR_W-1:0] OFF_RAW    = 12'h410;
  localparam logic [ADDR_W-1:0] OFF_RELOAD = 12'h418;
  localparam logic [ADDR_W-1:0] OFF_PREDIV = 12'h41C;
  localparam logic [ADDR_W-1:0] OFF_FREE   = 12'h420;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_IRQ_EN  = 5;
  localparam int unsigned CTRL_CD_EN   = 7;
  localparam int unsigned CTRL_DBG     = 8;
  localparam int unsigned CTRL_FR_EN   = 9;
  localparam int unsigned CTRL_FR_LSB  = 16;
  localparam int unsigned FR_PRE_W     = 8;
  localparam int unsigned PREDIV_W     = 10;
  localparam logic [31:0] CTRL_WR_MASK = 32'h00FF_03FF;
  localparam logic [31:0] CTRL_RST     = 32'h003E_0020;
  localparam logic [31:0] LOAD_RST     = 32'h0000_0000;
  localparam logic [31:0] FREE_RST     = 32'h0000_0000;
  localparam logic [PREDIV_W-1:0] PREDIV_RST = 10'h07D;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } tpfr_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tpfr_apb_rsp_s;

  typedef struct packed {
    logic [31:0]         load;
    logic [31:0]         value;
    logic [31:0]         ctrl;
    logic [31:0]         free;
    logic [31:0]         rdata;
    logic [PREDIV_W-1:0] prediv;
    logic                pend;
    logic                slverr;
    logic [2:0]          haltSync;
    logic                haltStable;
  } tpfr_state_s;

endpackage : tpfr_pkg

/* tpfr_prescaler.sv */
// Purpose: cycle-counting prescaler giving a one-cycle tick enable
// Assumes: divisor may change at any time; run low parks the count at zero
// Notes:   tick comes on the first running cycle, then every divisor+1 cycles

module tpfr_prescaler #(
  parameter int unsigned DivW = 10
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  input  wire logic            clkEn,
  // control
  input  wire logic            run,
  input  wire logic [DivW-1:0] divisor,
  // tick enable
  output logic                 tick
);

  typedef struct packed {
    logic [DivW-1:0] cnt;
  } tpfr_pre_s;

  tpfr_pre_s stateQ;
  tpfr_pre_s stateD;

  // no derived clock: a tick enable keeps one clock tree
  assign tick = run && (stateQ.cnt == '0);

  always_comb begin
    stateD = stateQ;
    if (!run) begin
      stateD.cnt = '0;
    end else if (stateQ.cnt >= divisor) begin
      stateD.cnt = '0;
    end else begin
      stateD.cnt = DivW'(stateQ.cnt + 1'b1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stateQ <= '0;
    end else if (clkEn) begin
      stateQ <= stateD;
    end
  end

endmodule : tpfr_prescaler

/* tpfr_top.sv */
// Purpose: countdown timer extension with tick divisor, deferred reload and free-running counter
// Assumes: apb slave on ref_clk, zero wait states; dbgHalt arrives asynchronously
// Notes:   irqAck is a same-clock pulse from the acknowledge logic; irqOut is combinational

module tpfr_top
  import tpfr_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic                    clkEn,
  // register bus
  input  wire tpfr_pkg::tpfr_apb_req_s apbReq,
  output tpfr_pkg::tpfr_apb_rsp_s      apbRsp,
  // timer side
  input  wire logic                    dbgHalt,
  input  wire logic                    irqAck,
  output logic                         irqOut
);
  import tpfr_pkg::*;

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  tpfr_state_s stateQ;
  tpfr_state_s stateD;

  logic setupPh;
  logic writePh;
  logic cdTick;
  logic frTick;
  logic haltActive;
  logic frRun;
  logic cdZero;
  logic wrLoad;
  logic wrReload;
  logic wrCtrl;
  logic wrPrediv;

  assign setupPh    = apbReq.psel && !apbReq.penable;
  assign writePh    = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign wrLoad     = writePh && (apbReq.paddr == OFF_LOAD);
  assign wrReload   = writePh && (apbReq.paddr == OFF_RELOAD);
  assign wrCtrl     = writePh && (apbReq.paddr == OFF_CTRL);
  assign wrPrediv   = writePh && (apbReq.paddr == OFF_PREDIV);
  assign haltActive = stateQ.ctrl[CTRL_DBG] && stateQ.haltStable;
  assign frRun      = stateQ.ctrl[CTRL_FR_EN] && !haltActive;
  assign cdZero     = cdTick && stateQ.ctrl[CTRL_CD_EN] && (stateQ.value == 32'h0000_0000);

  assign irqOut           = stateQ.pend && stateQ.ctrl[CTRL_IRQ_EN];
  assign apbRsp.pready    = 1'b1;
  assign apbRsp.pslverr   = stateQ.slverr && apbReq.psel && apbReq.penable;
  assign apbRsp.prdata    = stateQ.rdata;

  // ----------------------------------------------------------------
  // prescalers
  // ----------------------------------------------------------------
  tpfr_prescaler #(
    .DivW (PREDIV_W)
  ) u_cdPre (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .run     (!haltActive),
    .divisor (stateQ.prediv),
    .tick    (cdTick)
  );

  // independent of the countdown divisor
  tpfr_prescaler #(
    .DivW (FR_PRE_W)
  ) u_frPre (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .run     (frRun),
    .divisor (stateQ.ctrl[CTRL_FR_LSB +: FR_PRE_W]),
    .tick    (frTick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    stateD = stateQ;

    // three-stage sync; change accepted once stages two and three agree
    stateD.haltSync = {stateQ.haltSync[1:0], dbgHalt};
    if (stateQ.haltSync[1] == stateQ.haltSync[2]) begin
      stateD.haltStable = stateQ.haltSync[2];
    end

    // countdown
    if (cdTick && stateQ.ctrl[CTRL_CD_EN]) begin
      if (stateQ.value == 32'h0000_0000) begin
        stateD.value = stateQ.load;
      end else begin
        stateD.value = stateQ.value - 32'h0000_0001;
      end
    end

    // set wins over a same-cycle acknowledge
    if (irqAck) begin
      stateD.pend = 1'b0;
    end
    if (cdZero) begin
      stateD.pend = 1'b1;
    end

    // free-running counter: no write path, wraps naturally
    if (frTick) begin
      stateD.free = stateQ.free + 32'h0000_0001;
    end

    // register writes, access phase
    if (wrLoad) begin
      stateD.load  = apbReq.pwdata;
      stateD.value = apbReq.pwdata;
    end else if (wrReload) begin
      stateD.load = apbReq.pwdata;
    end else if (wrCtrl) begin
      stateD.ctrl = apbReq.pwdata & CTRL_WR_MASK;
    end else if (wrPrediv) begin
      stateD.prediv = apbReq.pwdata[PREDIV_W-1:0];
    end

    // read data captured in setup phase, ready for the access phase
    if (setupPh) begin
      stateD.slverr = 1'b0;
      stateD.rdata  = 32'h0000_0000;
      if (apbReq.paddr == OFF_LOAD || apbReq.paddr == OFF_RELOAD) begin
        stateD.rdata = stateQ.load;
      end else if (apbReq.paddr == OFF_VALUE) begin
        stateD.rdata = stateQ.value;
      end else if (apbReq.paddr == OFF_CTRL) begin
        stateD.rdata = stateQ.ctrl;
      end else if (apbReq.paddr == OFF_MASKED) begin
        stateD.rdata[0] = stateQ.pend && stateQ.ctrl[CTRL_IRQ_EN];
      end else if (apbReq.paddr == OFF_RAW) begin
        stateD.rdata[0] = stateQ.pend;
      end else if (apbReq.paddr == OFF_PREDIV) begin
        stateD.rdata[PREDIV_W-1:0] = stateQ.prediv;
      end else if (apbReq.paddr == OFF_FREE) begin
        stateD.rdata = stateQ.free;
      end else begin
        stateD.slverr = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stateQ        <= '0;
      stateQ.load   <= LOAD_RST;
      stateQ.value  <= LOAD_RST;
      stateQ.ctrl   <= CTRL_RST;
      stateQ.free   <= FREE_RST;
      stateQ.prediv <= PREDIV_RST;
    end else if (clkEn) begin
      stateQ <= stateD;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cbMain @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // tick spacing helper: cycles since the last countdown tick
  logic [PREDIV_W:0] gapCnt;
  logic              gapOk;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gapCnt <= '0;
      gapOk  <= 1'b0;
    end else if (clkEn) begin
      if (cdTick) begin
        gapCnt <= (PREDIV_W+1)'(1);
        gapOk  <= !wrPrediv && !haltActive;
      end else begin
        gapCnt <= (PREDIV_W+1)'(gapCnt + 1'b1);
        if (wrPrediv || haltActive) begin
          gapOk <= 1'b0;
        end
      end
    end
  end

  // free prescaler spacing helper; a control write or a stop voids the next gap
  logic [FR_PRE_W:0] frGapCnt;
  logic              frGapOk;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frGapCnt <= '0;
      frGapOk  <= 1'b0;
    end else if (clkEn) begin
      if (frTick) begin
        frGapCnt <= (FR_PRE_W+1)'(1);
        frGapOk  <= !wrCtrl && frRun;
      end else begin
        frGapCnt <= (FR_PRE_W+1)'(frGapCnt + 1'b1);
        if (wrCtrl || !frRun) begin
          frGapOk <= 1'b0;
        end
      end
    end
  end

  property p_maskedRead;
    clkEn && setupPh && (apbReq.paddr == OFF_MASKED)
      |=> apbRsp.prdata == {31'h0000_0000, $past(stateQ.pend) && $past(stateQ.ctrl[CTRL_IRQ_EN])};
  endproperty
  a_maskedRead: assert property (p_maskedRead) else $error("masked status read wrong");

  property p_maskedRo;
    clkEn && writePh && (apbReq.paddr == OFF_MASKED)
      |=> $stable(stateQ.ctrl) && $stable(stateQ.load) && $stable(stateQ.prediv);
  endproperty
  a_maskedRo: assert property (p_maskedRo) else $error("write to masked status changed state");

  property p_reloadStores;
    clkEn && wrReload |=> stateQ.load == $past(apbReq.pwdata);
  endproperty
  a_reloadStores: assert property (p_reloadStores) else $error("reload write not stored");

  property p_reloadDeferred;
    clkEn && wrReload && !(cdTick && stateQ.ctrl[CTRL_CD_EN]) |=> $stable(stateQ.value);
  endproperty
  a_reloadDeferred: assert property (p_reloadDeferred) else $error("reload write touched count");

  property p_loadImmediate;
    clkEn && wrLoad |=> stateQ.value == $past(apbReq.pwdata);
  endproperty
  a_loadImmediate: assert property (p_loadImmediate) else $error("load write did not reload");

  property p_zeroReload;
    clkEn && cdZero && !wrLoad && !wrReload |=> stateQ.value == $past(stateQ.load) && stateQ.pend;
  endproperty
  a_zeroReload: assert property (p_zeroReload) else $error("zero did not reload or set pending");

  property p_predivUpper;
    clkEn && setupPh && (apbReq.paddr == OFF_PREDIV) |=> apbRsp.prdata[31:PREDIV_W] == '0;
  endproperty
  a_predivUpper: assert property (p_predivUpper) else $error("divisor upper bits not zero");

  property p_tickPeriod;
    clkEn && cdTick && gapOk |-> gapCnt == (PREDIV_W+1)'({1'b0, stateQ.prediv} + 1'b1);
  endproperty
  a_tickPeriod: assert property (p_tickPeriod) else $error("countdown tick spacing wrong");

  property p_freeHold;
    !frRun |=> $stable(stateQ.free);
  endproperty
  a_freeHold: assert property (p_freeHold) else $error("free counter moved while stopped");

  property p_freeStart;
    clkEn && frRun && !$past(frRun) |=> stateQ.free == 32'($past(stateQ.free) + 32'h0000_0001);
  endproperty
  a_freeStart: assert property (p_freeStart) else $error("free counter start delayed");

  property p_freeWrap;
    clkEn && frTick && (stateQ.free == 32'hFFFF_FFFF) |=> stateQ.free == 32'h0000_0000;
  endproperty
  a_freeWrap: assert property (p_freeWrap) else $error("free counter did not wrap");

  property p_freeNoWrite;
    clkEn && writePh && (apbReq.paddr == OFF_FREE) && !frTick |=> $stable(stateQ.free);
  endproperty
  a_freeNoWrite: assert property (p_freeNoWrite) else $error("free counter written");

  property p_irqLine;
    stateQ.pend && !stateQ.ctrl[CTRL_IRQ_EN] |-> !irqOut;
  endproperty
  a_irqLine: assert property (p_irqLine) else $error("interrupt not blocked");

  property p_freePeriod;
    clkEn && frTick && frGapOk
      |-> frGapCnt == (FR_PRE_W+1)'({1'b0, stateQ.ctrl[CTRL_FR_LSB +: FR_PRE_W]} + 1'b1);
  endproperty
  a_freePeriod: assert property (p_freePeriod) else $error("free counter tick spacing wrong");

  property p_freeNeedsEn;
    !stateQ.ctrl[CTRL_FR_EN] |-> !frTick;
  endproperty
  a_freeNeedsEn: assert property (p_freeNeedsEn) else $error("free counter ticked while disabled");

  property p_haltStops;
    haltActive |-> !frTick && !cdTick;
  endproperty
  a_haltStops: assert property (p_haltStops) else $error("tick while debug halt active");

  property p_haltSync;
    clkEn && (stateQ.haltSync[1] != stateQ.haltSync[2]) |=> $stable(stateQ.haltStable);
  endproperty
  a_haltSync: assert property (p_haltSync) else $error("halt taken before sync stages agreed");

  property p_pendSetWins;
    clkEn && cdZero && irqAck |=> stateQ.pend;
  endproperty
  a_pendSetWins: assert property (p_pendSetWins) else $error("acknowledge beat a zero event");

  property p_pendAck;
    clkEn && irqAck && !cdZero |=> !stateQ.pend;
  endproperty
  a_pendAck: assert property (p_pendAck) else $error("acknowledge did not clear pending");

  property p_pendOnlyZero;
    clkEn && !stateQ.pend && !cdZero |=> !stateQ.pend;
  endproperty
  a_pendOnlyZero: assert property (p_pendOnlyZero) else $error("pending set without zero event");

  property p_countDown;
    clkEn && cdTick && stateQ.ctrl[CTRL_CD_EN] && (stateQ.value != 32'h0000_0000) && !wrLoad
      |=> stateQ.value == 32'($past(stateQ.value) - 32'h0000_0001);
  endproperty
  a_countDown: assert property (p_countDown) else $error("count did not step down on tick");

  property p_valueHold;
    clkEn && !(cdTick && stateQ.ctrl[CTRL_CD_EN]) && !wrLoad |=> $stable(stateQ.value);
  endproperty
  a_valueHold: assert property (p_valueHold) else $error("count moved without tick or load");

  property p_predivStore;
    clkEn && wrPrediv |=> stateQ.prediv == $past(apbReq.pwdata[PREDIV_W-1:0]);
  endproperty
  a_predivStore: assert property (p_predivStore) else $error("tick divisor write not stored");

  property p_cvZero;
    cdZero;
  endproperty
  c_cvZero: cover property (p_cvZero);

  property p_cvReload;
    wrReload ##[1:200] cdZero;
  endproperty
  c_cvReload: cover property (p_cvReload);

  property p_cvWrap;
    frTick && (stateQ.free == 32'hFFFF_FFFF);
  endproperty
  c_cvWrap: cover property (p_cvWrap);

  property p_cvHalt;
    stateQ.ctrl[CTRL_FR_EN] && haltActive;
  endproperty
  c_cvHalt: cover property (p_cvHalt);

endmodule : tpfr_top

/* tpfr_testbench.sv */
// Purpose: self-checking bench for tpfr_top
// Assumes: zero-wait apb, inputs change on the falling edge
// Notes:   a monitor checks each read against a queue of expected words
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tpfr_pkg::*;

  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } tpfr_exp_s;

  logic          ref_clk;
  logic          nrst;
  logic          clkEn;
  logic          dbgHalt;
  logic          irqAck;
  logic          irqOut;
  tpfr_apb_req_s apbReq;
  tpfr_apb_rsp_s apbRsp;
  tpfr_exp_s     expQ[$];
  int            errorCnt;
  int            checkCount;
  int            cycles = 0;
  int            n;
  logic [31:0]   q;
  logic [31:0]   f0;
  logic [31:0]   r;
  int            divs[4] = '{0, 1, 3, 125};
  logic [31:0]   ctl[6] = '{32'h0, 32'h0001_0000, 32'h0003_0000, 32'h0000_0100, 32'h0, 32'h0000_0100};
  logic          hlt[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [31:0]   inc[6] = '{32'd13, 32'd7, 32'd4, 32'd0, 32'd13, 32'd13};

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  tpfr_top u_dut (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .apbReq  (apbReq),
    .apbRsp  (apbRsp),
    .dbgHalt (dbgHalt),
    .irqAck  (irqAck),
    .irqOut  (irqOut)
  );

  // --------------------------------
  // checking and closing
  // --------------------------------
  task automatic fail(input string msg);
    errorCnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task automatic finish_test();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic cmp_rd(input tpfr_exp_s x, input logic [31:0] d, input logic e);
    checkCount++;
    if (((d & x.m) !== (x.d & x.m)) || (e !== x.e)) begin
      fail($sformatf("read %h/%b want %h/%b", d, e, x.d, x.e));
    end
  endtask : cmp_rd

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fail($sformatf("value %0d want %0d", got, exp));
    end
  endtask : cmp_val

  // reads are judged where the access phase is sampled
  always @(posedge ref_clk) begin
    if (nrst && apbReq.psel && apbReq.penable && !apbReq.pwrite) begin
      if (expQ.size() == 0) begin
        fail("read with no expectation");
      end else begin
        cmp_rd(expQ.pop_front(), apbRsp.prdata, apbRsp.pslverr);
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail("timeout");
      finish_test();
    end
  end

  // --------------------------------
  // bus and pin tasks
  // --------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(negedge ref_clk);
    apbReq.psel = 1'b1;
    apbReq.penable = 1'b0;
    apbReq.pwrite = w;
    apbReq.paddr = a;
    apbReq.pwdata = wd;
    @(negedge ref_clk);
    apbReq.penable = 1'b1;
    @(posedge ref_clk);
    rd = apbRsp.prdata;
    @(negedge ref_clk);
    apbReq.psel = 1'b0;
    apbReq.penable = 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic e,
                    output logic [31:0] v);
    expQ.push_back('{d, m, e});
    bus(1'b0, a, 32'h0000_0000, v);
  endtask : rd

  task automatic rq(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] t;
    rd(a, d, 32'hFFFF_FFFF, 1'b0, t);
  endtask : rq

  // bounded so a dead interrupt cannot hang the run
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (irqOut !== 1'b1 && k < 3000);
  endtask : wait_irq

  task automatic ack();
    irqAck = 1'b1;
    @(negedge ref_clk);
    irqAck = 1'b0;
  endtask : ack

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    dbgHalt = 1'b0;
    irqAck = 1'b0;
    apbReq = '0;
    errorCnt = 0;
    checkCount = 0;
    void'($urandom(66609));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    rq(OFF_CTRL, CTRL_RST);
    rq(OFF_MASKED, 32'h0000_0000);
    rq(OFF_PREDIV, 32'(PREDIV_RST));
    rq(OFF_FREE, FREE_RST);
    rd(12'h500, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1, q);
    wr(OFF_PREDIV, 32'hFFFF_FFFF);
    rq(OFF_PREDIV, 32'h0000_03FF);
    r = $urandom;
    wr(OFF_PREDIV, r);
    rq(OFF_PREDIV, r & 32'h0000_03FF);
    // deferred reload with the countdown stopped, then running
    wr(OFF_PREDIV, 32'h0000_003F);
    wr(OFF_LOAD, 32'h0000_0002);
    rq(OFF_VALUE, 32'h0000_0002);
    r = ($urandom % 200) + 3;
    wr(OFF_RELOAD, r);
    rq(OFF_VALUE, 32'h0000_0002);
    rq(OFF_LOAD, r);
    wr(OFF_CTRL, 32'h0000_00A0);
    wait_irq(n);
    rq(OFF_VALUE, r);
    // zero-event spacing: load 2 gives three ticks per period
    foreach (divs[i]) begin
      wr(OFF_PREDIV, 32'(divs[i]));
      wr(OFF_LOAD, 32'h0000_0002);
      ack();
      wait_irq(n);
      ack();
      cmp_val({31'h0, irqOut}, 32'h0);
      wait_irq(n);
      cmp_val(32'(n + 1), 32'(3 * (divs[i] + 1)));
    end
    wr(OFF_CTRL, 32'h0000_0000);
    cmp_val({31'h0, irqOut}, 32'h0);
    rq(OFF_MASKED, 32'h0000_0000);
    rq(OFF_RAW, 32'h0000_0001);
    wr(OFF_MASKED, 32'hFFFF_FFFF);
    wr(OFF_CTRL, 32'h0000_0020);
    cmp_val({31'h0, irqOut}, 32'h1);
    rq(OFF_MASKED, 32'h0000_0001);
    ack();
    rq(OFF_MASKED, 32'h0000_0000);
    // free counter: 13 enabled cycles per case
    f0 = FREE_RST;
    for (int i = 0; i < 6; i++) begin
      dbgHalt = hlt[i];
      repeat (6) @(negedge ref_clk);
      rd(OFF_FREE, f0, 32'hFFFF_FFFF, 1'b0, q);
      wr(OFF_CTRL, ctl[i] | 32'h0000_0200);
      repeat (10) @(negedge ref_clk);
      wr(OFF_CTRL, ctl[i]);
      f0 = f0 + inc[i];
      rq(OFF_FREE, f0);
      rq(OFF_FREE, f0);
    end
    wr(OFF_FREE, 32'h0000_0000);
    rq(OFF_FREE, f0);
    // clock enable low freezes the counter: 3 live enabled edges remain
    wr(OFF_CTRL, 32'h0000_0200);
    clkEn = 1'b0;
    repeat (20) @(negedge ref_clk);
    clkEn = 1'b1;
    wr(OFF_CTRL, 32'h0000_0000);
    rq(OFF_FREE, f0 + 32'h0000_0003);
    finish_test();
  end

endmodule : testbench
